// [rtl/basis_regs_pkg.sv]
// Constants, field layouts and carrier types for the reference and excitation register bank.
// Assumes a single 125 MHz clock domain and an AXI4-Lite master on the register side.
//
// Contract
// - Reference monitor field: 00 off, 01 low, 10 low and high, 11 low plus pull-together.
// - Positive buffer bypass bit: clear enables buffer, set disables; resets clear.
// - Negative buffer bypass bit: clear enables buffer, set disables; resets set.
// - Reference select: 00 pair zero, 01 pair one, 10 internal, 11 reserved.
// - Internal reference: 00 off, 01 on except power-down, 10 always on, 11 reserved.
// - Rail monitor enable bit turns the amplifier rail monitor on when set.
// - Low-side switch closes when set, opens when clear, forced open in power-down.
// - Four-bit magnitude sets both current sources alike, 0000 off to 1000 top.
// - First excitation register sits at 06h and resets to 00h.
// - Second excitation register sits at 07h and resets to FFh.
// - Second excitation register: source two in 7:4, source one in 3:0; 1101+ disconnected.
// - Reference control register sits at 05h and resets to 10h.

`default_nettype none

package basis_regs_pkg;

	// ------------------------------------------------------------
	// Register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_BASIS      = 8'h05;
	localparam logic [7:0] OFS_EXC_MAG    = 8'h06;
	localparam logic [7:0] OFS_EXC_ROUTE  = 8'h07;
	localparam logic [7:0] RST_BASIS      = 8'h10;
	localparam logic [7:0] RST_EXC_MAG    = 8'h00;
	localparam logic [7:0] RST_EXC_ROUTE  = 8'hFF;
	localparam logic [7:0] EXC_MAG_WMASK  = 8'hCF;
	localparam int         REG_W          = 8;

	// ------------------------------------------------------------
	// Field encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MON_OFF        = 2'h0;
	localparam logic [1:0] MON_LOW        = 2'h1;
	localparam logic [1:0] MON_LOW_HIGH   = 2'h2;
	localparam logic [1:0] MON_LOW_PULL   = 2'h3;
	localparam logic [1:0] SEL_INTERNAL   = 2'h2;
	localparam logic [1:0] SEL_RESERVED   = 2'h3;
	localparam logic [1:0] INT_OFF        = 2'h0;
	localparam logic [1:0] INT_ON_RUN     = 2'h1;
	localparam logic [1:0] INT_ON_ALWAYS  = 2'h2;
	localparam logic [3:0] MAG_OFF        = 4'h0;
	localparam logic [3:0] MAG_MAX        = 4'h8;
	localparam logic [3:0] CHAN_LAST      = 4'hC;

	localparam logic [1:0] AXI_OKAY       = 2'h0;
	localparam logic [1:0] AXI_SLVERR     = 2'h2;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] basis_monitor_cfg;
		logic       pos_buffer_bypass;
		logic       neg_buffer_bypass;
		logic [1:0] basis_input_select;
		logic [1:0] internal_basis_cfg;
	} basis_ctl_s;

	typedef struct packed {
		logic       rail_monitor_enable;
		logic       low_side_switch;
		logic [1:0] zero_bits;
		logic [3:0] excitation_magnitude;
	} exc_mag_s;

	typedef struct packed {
		logic [3:0] source_two_channel;
		logic [3:0] source_one_channel;
	} exc_route_s;

	// Decoded analog controls handed to the converter core.
	typedef struct packed {
		logic       low_monitor_on;
		logic       high_monitor_on;
		logic       pull_together_on;
		logic       pos_buffer_on;
		logic       neg_buffer_on;
		logic [1:0] basis_input_select;
		logic       internal_basis_on;
		logic       rail_monitor_on;
		logic       switch_closed;
		logic [3:0] excitation_magnitude;
		logic       source_one_connected;
		logic       source_two_connected;
		logic [3:0] source_one_channel;
		logic [3:0] source_two_channel;
	} analog_ctl_s;

endpackage : basis_regs_pkg

`default_nettype wire

// [rtl/basis_reg_store.sv]
// Small three-word register store with registered read data.
// Assumes write and read index come from the bus slave in the same clock domain.

`default_nettype none

module basis_reg_store (
	input  wire logic                                 aclk,
	input  wire logic                                 aresetn,
	input  wire logic                                 clk_en,
	input  wire logic                                 wr_en,
	input  wire logic [1:0]                           wr_idx,
	input  wire logic [basis_regs_pkg::REG_W-1:0]     wr_data,
	input  wire logic                                 rd_en,
	input  wire logic [1:0]                           rd_idx,
	output var  logic [basis_regs_pkg::REG_W-1:0]     rd_data,
	output var  logic [3*basis_regs_pkg::REG_W-1:0]   words
);
	import basis_regs_pkg::*;

	logic [REG_W-1:0] mem [3];

	// Index 1 is the first excitation register; its zero bits are never stored.
	wire logic [REG_W-1:0] masked_data = (wr_idx == 2'd1) ? (wr_data & EXC_MAG_WMASK) : wr_data;

	assign words = {mem[2], mem[1], mem[0]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem[0]  <= RST_BASIS;
			mem[1]  <= RST_EXC_MAG;
			mem[2]  <= RST_EXC_ROUTE;
			rd_data <= '0;
		end else if (clk_en) begin
			if (wr_en && wr_idx != 2'd3)
				mem[wr_idx] <= masked_data;
			if (rd_en)
				rd_data <= (rd_idx == 2'd3) ? '0 : mem[rd_idx];
		end
	end

endmodule : basis_reg_store

`default_nettype wire

// [rtl/basis_excitation_regs.sv]
// AXI4-Lite register bank for reference control and excitation current setup.
// Assumes one clock, a synchronous active-low reset and a power-down level from the core.

`default_nettype none

module basis_excitation_regs (
	input  wire logic                                aclk,
	input  wire logic                                aresetn,
	input  wire logic                                clk_en,
	input  wire logic                                power_down,
	input  wire logic [7:0]                          s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output var  logic                                s_axi_awready,
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output var  logic                                s_axi_wready,
	output var  logic [1:0]                          s_axi_bresp,
	output var  logic                                s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	input  wire logic [7:0]                          s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output var  logic                                s_axi_arready,
	output var  logic [31:0]                         s_axi_rdata,
	output var  logic [1:0]                          s_axi_rresp,
	output var  logic                                s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	output var  basis_regs_pkg::analog_ctl_s         analog_ctl
);
	import basis_regs_pkg::*;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Registers sit on word boundaries at four times the printed index.
	function automatic logic [1:0] decode(input logic [7:0] addr);
		if (addr == {OFS_BASIS[5:0], 2'b00})
			decode = 2'd0;
		else if (addr == {OFS_EXC_MAG[5:0], 2'b00})
			decode = 2'd1;
		else if (addr == {OFS_EXC_ROUTE[5:0], 2'b00})
			decode = 2'd2;
		else
			decode = 2'd3;
	endfunction

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	logic       aw_held;
	logic       w_held;
	logic [7:0] aw_addr;
	logic [7:0] w_data;
	logic       w_lane;

	// Ready is held low while frozen so that no handshake is lost to a stalled edge.
	assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;

	wire logic       aw_take  = s_axi_awvalid && s_axi_awready;
	wire logic       w_take   = s_axi_wvalid && s_axi_wready;
	wire logic       aw_have  = aw_held || aw_take;
	wire logic       w_have   = w_held || w_take;
	wire logic [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
	wire logic [7:0] wr_byte  = w_held ? w_data : s_axi_wdata[7:0];
	wire logic       wr_lane  = w_held ? w_lane : s_axi_wstrb[0];
	wire logic [1:0] wr_idx   = decode(wr_addr);
	wire logic       wr_fire  = aw_have && w_have && !s_axi_bvalid;
	// Only byte lane 0 carries data; a write without it stores nothing.
	wire logic       wr_store = wr_fire && wr_lane && wr_idx != 2'd3;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			w_lane       <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == 2'd3) ? AXI_SLVERR : AXI_OKAY;
			end else begin
				if (aw_take) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata[7:0];
					w_lane <= s_axi_wstrb[0];
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	logic [1:0] rd_idx_q;
	logic       rd_pend;

	assign s_axi_arready = clk_en && !rd_pend && !s_axi_rvalid;

	wire logic       ar_take = s_axi_arvalid && s_axi_arready;
	wire logic [1:0] rd_idx  = decode(s_axi_araddr);
	wire logic [7:0] rd_word;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend      <= 1'b0;
			rd_idx_q     <= '0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= AXI_OKAY;
		end else if (clk_en) begin
			rd_pend <= ar_take;
			if (ar_take)
				rd_idx_q <= rd_idx;
			if (rd_pend) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (rd_idx_q == 2'd3) ? AXI_SLVERR : AXI_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Upper bits of every word read as zero.
	assign s_axi_rdata = {24'h000000, rd_word};

	// ------------------------------------------------------------
	// Register store
	// ------------------------------------------------------------
	wire logic [3*REG_W-1:0] words;

	basis_reg_store u_store (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clk_en  (clk_en),
		.wr_en   (wr_store),
		.wr_idx  (wr_idx),
		.wr_data (wr_byte),
		.rd_en   (ar_take),
		.rd_idx  (rd_idx),
		.rd_data (rd_word),
		.words   (words)
	);

	// ------------------------------------------------------------
	// Field decode toward the converter core
	// ------------------------------------------------------------
	wire basis_ctl_s basis = basis_ctl_s'(words[REG_W-1:0]);
	wire exc_mag_s   mag   = exc_mag_s'(words[2*REG_W-1:REG_W]);
	wire exc_route_s route = exc_route_s'(words[3*REG_W-1:2*REG_W]);

	wire logic low_mon  = basis.basis_monitor_cfg != MON_OFF;
	wire logic high_mon = basis.basis_monitor_cfg == MON_LOW_HIGH;
	wire logic pull_mon = basis.basis_monitor_cfg == MON_LOW_PULL;
	// Reserved internal-reference code is treated as off.
	wire logic int_on   = (basis.internal_basis_cfg == INT_ON_ALWAYS)
		|| (basis.internal_basis_cfg == INT_ON_RUN && !power_down);
	// The switch drops open in power-down whatever software last wrote.
	wire logic sw_close = mag.low_side_switch && !power_down;
	// Codes above the top magnitude are undefined; they drive the sources off.
	wire logic [3:0] mag_eff = (mag.excitation_magnitude > MAG_MAX)
		? MAG_OFF : mag.excitation_magnitude;
	wire logic one_conn = route.source_one_channel <= CHAN_LAST;
	wire logic two_conn = route.source_two_channel <= CHAN_LAST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_ctl <= '0;
			analog_ctl.neg_buffer_on <= 1'b0;
		end else if (clk_en) begin
			analog_ctl.low_monitor_on       <= low_mon;
			analog_ctl.high_monitor_on      <= high_mon;
			analog_ctl.pull_together_on     <= pull_mon;
			analog_ctl.pos_buffer_on        <= !basis.pos_buffer_bypass;
			analog_ctl.neg_buffer_on        <= !basis.neg_buffer_bypass;
			analog_ctl.basis_input_select   <= basis.basis_input_select;
			analog_ctl.internal_basis_on    <= int_on;
			analog_ctl.rail_monitor_on      <= mag.rail_monitor_enable;
			analog_ctl.switch_closed        <= sw_close;
			analog_ctl.excitation_magnitude <= mag_eff;
			analog_ctl.source_one_connected <= one_conn;
			analog_ctl.source_two_connected <= two_conn;
			analog_ctl.source_one_channel   <= route.source_one_channel;
			analog_ctl.source_two_channel   <= route.source_two_channel;
		end
	end

endmodule : basis_excitation_regs

`default_nettype wire

// [testbench/basis_regs_chk.sv]
// Port-level checks for the reference and excitation register bank.
// Assumes it is bound onto basis_excitation_regs and sees one clock domain.
`default_nettype none
module basis_regs_chk (
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic                        clk_en,
	input wire logic                        power_down,
	input wire logic                        s_axi_awvalid,
	input wire logic                        s_axi_awready,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_arvalid,
	input wire logic                        s_axi_arready,
	input wire logic                        s_axi_rvalid,
	input wire logic [31:0]                 s_axi_rdata,
	input wire logic [1:0]                  s_axi_rresp,
	input wire basis_regs_pkg::analog_ctl_s analog_ctl
);
	timeunit 1ns;
	timeprecision 1ps;
	import basis_regs_pkg::*;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	wire logic wr_go = clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic rd_go = clk_en && s_axi_arvalid && s_axi_arready;
	wire analog_ctl_s c = analog_ctl;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wr_answer; wr_go |=> s_axi_bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
	property p_rd_answer; rd_go ##1 clk_en |-> !s_axi_rvalid ##1 s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer mistimed");
	property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("read upper bits set");
	property p_rd_err; s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0; endproperty
	a_rd_err: assert property (p_rd_err) else $error("error read carries data");
	property p_monitor; c.high_monitor_on || c.pull_together_on
		|-> c.low_monitor_on && !(c.high_monitor_on && c.pull_together_on); endproperty
	a_monitor: assert property (p_monitor) else $error("monitor decode wrong");
	property p_magnitude; c.excitation_magnitude <= MAG_MAX; endproperty
	a_magnitude: assert property (p_magnitude) else $error("magnitude out of range");
	property p_route; $past(aresetn) |-> c.source_one_connected == (c.source_one_channel <= CHAN_LAST)
		&& c.source_two_connected == (c.source_two_channel <= CHAN_LAST); endproperty
	a_route: assert property (p_route) else $error("source connect wrong");
	property p_power_down; power_down && clk_en |=> !c.switch_closed; endproperty
	a_power_down: assert property (p_power_down) else $error("switch closed in power-down");
	property p_reset; $rose(aresetn) |-> ##2 c.pos_buffer_on && !c.neg_buffer_on; endproperty
	a_reset: assert property (p_reset) else $error("buffer reset state wrong");
endmodule // basis_regs_chk
bind basis_excitation_regs basis_regs_chk chk (.*);
`default_nettype wire

// [testbench/axil_host.sv]
// AXI4-Lite master standing in for the host controller.
// Assumes its tasks are called from one process clocked by aclk.
`default_nettype none
module axil_host (
	input  wire logic        aclk,
	output var  logic [7:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	output var  logic [7:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Handshakes are judged mid-cycle so the edge that acts never races the slave.
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw, w, go;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			go = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			// Released lines show the inverse so stale values cannot pass.
			if (aw) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (w) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
		end while (!go);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, go;
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			go = s_axi_rvalid;
			{d, r} = {s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ar) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		end while (!go);
		s_axi_rready <= 1'b0;
	endtask
endmodule // axil_host
`default_nettype wire

// [testbench/reference_and_excitation_regs_tb_top.sv]
// Self-checking bench for the reference and excitation register bank.
// Assumes the host model drives the bus; the bench drives reset and power-down.
`default_nettype none
module reference_and_excitation_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import basis_regs_pkg::*;
	localparam logic [7:0] A_B = OFS_BASIS << 2;
	localparam logic [7:0] A_M = OFS_EXC_MAG << 2;
	localparam logic [7:0] A_X = OFS_EXC_ROUTE << 2;
	logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, power_down = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr, b, m, x;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	analog_ctl_s analog_ctl;
	int miscompares = 0, checks_done = 0;
	always #4 aclk = ~aclk;
	basis_excitation_regs dut (.*);
	axil_host host (.*);
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic test_done();
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic analog_ctl_s exp_ctl();
		exp_ctl.low_monitor_on = b[7:6] != 2'b00;
		exp_ctl.high_monitor_on = b[7:6] == 2'b10;
		exp_ctl.pull_together_on = b[7:6] == 2'b11;
		exp_ctl.pos_buffer_on = !b[5];
		exp_ctl.neg_buffer_on = !b[4];
		exp_ctl.basis_input_select = b[3:2];
		exp_ctl.internal_basis_on = b[1:0] == 2'b10 || (b[1:0] == 2'b01 && !power_down);
		exp_ctl.rail_monitor_on = m[7];
		exp_ctl.switch_closed = m[6] && !power_down;
		exp_ctl.excitation_magnitude = m[3:0] > 4'h8 ? 4'h0 : m[3:0];
		exp_ctl.source_one_connected = x[3:0] < 4'hD;
		exp_ctl.source_two_connected = x[7:4] < 4'hD;
		exp_ctl.source_one_channel = x[3:0];
		exp_ctl.source_two_channel = x[7:4];
	endfunction
	task automatic rd_chk(input logic [7:0] a);
		logic [1:0]  r;
		logic [31:0] q;
		host.rd(a, q, r);
		chk(32'(r), 32'(AXI_OKAY));
		chk(q, {24'h0, a == A_B ? b : a == A_M ? m : x});
		@(negedge aclk);
		chk(32'(analog_ctl), 32'(exp_ctl()));
	endtask
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		host.wr(a, d, s, r);
		chk(32'(r), 32'(AXI_OKAY));
		if (s[0] && a == A_B) b = d[7:0];
		if (s[0] && a == A_M) m = d[7:0] & 8'hCF;
		if (s[0] && a == A_X) x = d[7:0];
		rd_chk(a);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_reset();
		{b, m, x} = {8'h10, 8'h00, 8'hFF};
		rd_chk(A_B);
		rd_chk(A_M);
		rd_chk(A_X);
	endtask
	task automatic s_basis();
		for (int i = 0; i < 4; i++)
			wr_chk(A_B, {24'h0, 2'(i), i != 0, i != 1, 2'(i), 2'(i)}, 4'hF);
		wr_chk(A_B, 32'h3A, 4'hF);
	endtask
	task automatic s_exc();
		wr_chk(A_M, 32'hFF, 4'hF);
		for (int k = 0; k < 9; k++)
			wr_chk(A_M, {24'h0, k[0], k[1], 2'b00, 4'(k)}, 4'hF);
	endtask
	task automatic s_pd();
		wr_chk(A_B, 32'h39, 4'hF);
		wr_chk(A_M, 32'h48, 4'hF);
		@(posedge aclk);
		power_down <= 1'b1;
		rd_chk(A_M);
		@(posedge aclk);
		power_down <= 1'b0;
		rd_chk(A_B);
	endtask
	// Power-down rises while frozen: the closed switch must hold until the enable returns.
	task automatic s_freeze();
		@(posedge aclk);
		{clk_en, power_down} <= 2'b01;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk(32'(analog_ctl.switch_closed), 32'(m[6]));
		@(posedge aclk);
		clk_en <= 1'b1;
		rd_chk(A_M);
		@(posedge aclk);
		power_down <= 1'b0;
	endtask
	task automatic s_err();
		logic [1:0]  r;
		logic [31:0] q;
		wr_chk(A_X, 32'hC0, 4'hF);
		wr_chk(A_X, 32'hFFFF_FFDC, 4'hF);
		host.wr(8'h20, 32'h55, 4'hF, r);
		chk(32'(r), 32'(AXI_SLVERR));
		host.rd(8'h20, q, r);
		chk(32'(r), 32'(AXI_SLVERR));
		chk(q, 32'h0);
		wr_chk(A_X, 32'h12, 4'h0);
	endtask
	initial begin
		#100000;
		miscompares++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset();
		s_basis();
		s_exc();
		s_pd();
		s_freeze();
		s_err();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset();
		test_done();
	end
endmodule // reference_and_excitation_regs_tb_top
`default_nettype wire
